// [hdl/pif_flags.v]
// Peripheral interrupt flag registers with enables and an APB slave
//
// Overview of operation
// - A flag sets on its peripheral's request whatever its enable or the global enable.
// - A flag bit reads one while its interrupt is pending and zero while it is not.
// - Register one holds timer1 gate, adc, serial, capture1, timer2 match and timer1 overflow flags.
// - The uart receive and transmit flags at bits 5 and 4 are read-only; other flags are read-write.
// - Every flag clears to zero on every reset.
// - Register two holds oscillator fail, comparator1, eeprom done, bus collision and capture2 flags.
// - The comparator2 flag at bit 6 of register two exists only on the larger variant.
// - Register three holds capture4, capture3, timer6 match and timer4 match flags.
// - Unimplemented flag bits always read as zero.
// - Timer6 and timer4 flags set when their timer matches its period value.
// - A pending flag raises periph_irq only with its own enable and the peripheral enable set; with its own enable alone it can raise irq through the wake event.
// - A flag with its enable set requests wake-up whatever the global enable.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pif_defs.vh"

module pif_flags #(
  parameter LARGE_VARIANT = 1
) (
  // System
  input  wire        clk_sys,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Peripheral set pulses, register one
  input  wire        timer1_gate_set,
  input  wire        adc_done_set,
  input  wire        uart_rx_set,
  input  wire        uart_tx_set,
  input  wire        sync_serial_set,
  input  wire        capture1_set,
  input  wire        timer2_match_set,
  input  wire        timer1_overflow_set,
  // Uart clears, owned by the uart itself
  input  wire        uart_rx_clr,
  input  wire        uart_tx_clr,
  // Peripheral set pulses, register two
  input  wire        osc_fail_set,
  input  wire        comparator2_set,
  input  wire        comparator1_set,
  input  wire        eeprom_write_done_set,
  input  wire        bus_collision_set,
  input  wire        capture2_set,
  // Peripheral set pulses, register three
  input  wire        capture4_set,
  input  wire        capture3_set,
  input  wire        timer6_match_set,
  input  wire        timer4_match_set,
  // Requests to the core
  output reg         periph_irq,
  output reg         wake_req,
  output reg         irq
);

  // ------------------------------------------------------------
  // Implemented bit masks
  // ------------------------------------------------------------
  localparam [7:0] IMPL_TWO = (LARGE_VARIANT != 0) ?
                              `PIF_IMPL_TWO_LARGE : `PIF_IMPL_TWO_SMALL;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Write under mask, then OR in new requests so a set wins
  function [7:0] upd;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] wmask;
    input [7:0] wdat;
    input       we;
    input [7:0] impl;
    reg   [7:0] kept;
    begin
      kept = we ? ((cur & ~wmask) | (wdat & wmask)) : cur;
      upd  = (kept | set) & impl;
    end
  endfunction

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [7:0] periph_flags_one;
  reg  [7:0] periph_flags_two;
  reg  [7:0] periph_flags_three;
  reg  [7:0] periph_en_one;
  reg  [7:0] periph_en_two;
  reg  [7:0] periph_en_three;
  reg  [7:0] core_int_control;
  reg  [7:0] evt_status;
  reg  [7:0] evt_mask;
  reg        irq_cond_q;
  reg        wake_cond_q;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire       access = psel & penable;
  wire       commit = access & pready;
  wire       wr     = commit & pwrite;
  wire [7:0] wd     = pwdata[7:0];
  reg        mapped;

  always @* begin
    if (hit(paddr, `PIF_OFS_FLAGS_ONE)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_FLAGS_TWO)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_FLAGS_THREE)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_EN_ONE)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_EN_TWO)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_EN_THREE)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_CORE_CTRL)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_EVT_STATUS)) begin
      mapped = 1'b1;
    end else if (hit(paddr, `PIF_OFS_EVT_MASK)) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Request vectors
  // ------------------------------------------------------------
  reg [7:0] set_one;
  reg [7:0] set_two;
  reg [7:0] set_three;

  always @* begin
    set_one   = 8'h00;
    set_two   = 8'h00;
    set_three = 8'h00;
    set_one[`PIF_B1_TIMER1_GATE]  = timer1_gate_set;
    set_one[`PIF_B1_ADC_DONE]     = adc_done_set;
    set_one[`PIF_B1_UART_RX]      = uart_rx_set;
    set_one[`PIF_B1_UART_TX]      = uart_tx_set;
    set_one[`PIF_B1_SYNC_SERIAL]  = sync_serial_set;
    set_one[`PIF_B1_CAPTURE1]     = capture1_set;
    set_one[`PIF_B1_TIMER2_MATCH] = timer2_match_set;
    set_one[`PIF_B1_TIMER1_OVF]   = timer1_overflow_set;
    set_two[`PIF_B2_OSC_FAIL]     = osc_fail_set;
    set_two[`PIF_B2_COMPARATOR2]  = comparator2_set;
    set_two[`PIF_B2_COMPARATOR1]  = comparator1_set;
    set_two[`PIF_B2_EEPROM_DONE]  = eeprom_write_done_set;
    set_two[`PIF_B2_BUS_COLL]     = bus_collision_set;
    set_two[`PIF_B2_CAPTURE2]     = capture2_set;
    set_three[`PIF_B3_CAPTURE4]     = capture4_set;
    set_three[`PIF_B3_CAPTURE3]     = capture3_set;
    set_three[`PIF_B3_TIMER6_MATCH] = timer6_match_set;
    set_three[`PIF_B3_TIMER4_MATCH] = timer4_match_set;
  end

  // ------------------------------------------------------------
  // Uart flags follow their own peripheral, not software
  // ------------------------------------------------------------
  reg [7:0] uart_clr;

  always @* begin
    uart_clr = 8'h00;
    uart_clr[`PIF_B1_UART_RX] = uart_rx_clr;
    uart_clr[`PIF_B1_UART_TX] = uart_tx_clr;
  end

  // ------------------------------------------------------------
  // Next flag values
  // ------------------------------------------------------------
  wire       we_one   = wr & hit(paddr, `PIF_OFS_FLAGS_ONE);
  wire       we_two   = wr & hit(paddr, `PIF_OFS_FLAGS_TWO);
  wire       we_three = wr & hit(paddr, `PIF_OFS_FLAGS_THREE);
  wire [7:0] next_flags_one;
  wire [7:0] next_flags_two;
  wire [7:0] next_flags_three;

  // Software writes touch only writable bits; sets always win
  assign next_flags_one   = upd(periph_flags_one & ~uart_clr, set_one,
                                `PIF_WR_ONE, wd, we_one, `PIF_IMPL_ONE);
  assign next_flags_two   = upd(periph_flags_two, set_two,
                                IMPL_TWO, wd, we_two, IMPL_TWO);
  assign next_flags_three = upd(periph_flags_three, set_three,
                                `PIF_IMPL_THREE, wd, we_three,
                                `PIF_IMPL_THREE);

  // ------------------------------------------------------------
  // Interrupt and wake conditions
  // ------------------------------------------------------------
  // Enabling over a stale flag fires at once; software clears first
  wire any_pending = |(periph_flags_one & periph_en_one) |
                     |(periph_flags_two & periph_en_two) |
                     |(periph_flags_three & periph_en_three);
  wire next_irq_cond  = any_pending &
                        core_int_control[`PIF_CC_PERIPH_EN];
  wire next_wake_cond = any_pending;

  // ------------------------------------------------------------
  // Event status, W1C with set priority
  // ------------------------------------------------------------
  reg [7:0] evt_set;

  always @* begin
    evt_set = 8'h00;
    evt_set[`PIF_EVT_IRQ_RAISED]  = next_irq_cond & ~irq_cond_q;
    evt_set[`PIF_EVT_WAKE_RAISED] = next_wake_cond & ~wake_cond_q;
  end

  wire [7:0] evt_clr = (wr & hit(paddr, `PIF_OFS_EVT_STATUS)) ? wd : 8'h00;
  wire [7:0] next_evt_status = ((evt_status & ~evt_clr) | evt_set) & `PIF_EVT_MASK;

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  reg [7:0] rd;

  always @* begin
    if (hit(paddr, `PIF_OFS_FLAGS_ONE)) begin
      rd = periph_flags_one;
    end else if (hit(paddr, `PIF_OFS_FLAGS_TWO)) begin
      rd = periph_flags_two & IMPL_TWO;
    end else if (hit(paddr, `PIF_OFS_FLAGS_THREE)) begin
      rd = periph_flags_three & `PIF_IMPL_THREE;
    end else if (hit(paddr, `PIF_OFS_EN_ONE)) begin
      rd = periph_en_one;
    end else if (hit(paddr, `PIF_OFS_EN_TWO)) begin
      rd = periph_en_two;
    end else if (hit(paddr, `PIF_OFS_EN_THREE)) begin
      rd = periph_en_three;
    end else if (hit(paddr, `PIF_OFS_CORE_CTRL)) begin
      rd = core_int_control;
    end else if (hit(paddr, `PIF_OFS_EVT_STATUS)) begin
      rd = evt_status;
    end else if (hit(paddr, `PIF_OFS_EVT_MASK)) begin
      rd = evt_mask;
    end else begin
      rd = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // APB handshake: one wait state, answer registered
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `PIF_RST_DATA;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      if (access & ~pready & ~pwrite) begin
        prdata <= {24'h00_0000, rd};
      end else begin
        prdata <= `PIF_RST_DATA;
      end
    end
  end

  // ------------------------------------------------------------
  // Flag registers
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      periph_flags_one   <= `PIF_RST_FLAGS;
      periph_flags_two   <= `PIF_RST_FLAGS;
      periph_flags_three <= `PIF_RST_FLAGS;
    end else begin
      periph_flags_one   <= next_flags_one;
      periph_flags_two   <= next_flags_two;
      periph_flags_three <= next_flags_three;
    end
  end

  // ------------------------------------------------------------
  // Enable and control registers
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rstn) begin
      periph_en_one    <= `PIF_RST_ENABLES;
      periph_en_two    <= `PIF_RST_ENABLES;
      periph_en_three  <= `PIF_RST_ENABLES;
      core_int_control <= `PIF_RST_CTRL;
      evt_mask         <= `PIF_RST_CTRL;
    end else if (wr) begin
      if (hit(paddr, `PIF_OFS_EN_ONE)) begin
        periph_en_one <= wd & `PIF_IMPL_ONE;
      end else if (hit(paddr, `PIF_OFS_EN_TWO)) begin
        periph_en_two <= wd & IMPL_TWO;
      end else if (hit(paddr, `PIF_OFS_EN_THREE)) begin
        periph_en_three <= wd & `PIF_IMPL_THREE;
      end else if (hit(paddr, `PIF_OFS_CORE_CTRL)) begin
        core_int_control <= wd & `PIF_CC_MASK;
      end else if (hit(paddr, `PIF_OFS_EVT_MASK)) begin
        evt_mask <= wd & `PIF_EVT_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs to the core
  // ------------------------------------------------------------
  // Global enable gating is the core's job; no output uses it here, and wake also ignores the peripheral enable
  always @(posedge clk_sys) begin
    if (!rstn) begin
      irq_cond_q  <= 1'b0;
      wake_cond_q <= 1'b0;
      periph_irq  <= 1'b0;
      wake_req    <= 1'b0;
      evt_status  <= `PIF_RST_CTRL;
      irq         <= 1'b0;
    end else begin
      irq_cond_q  <= next_irq_cond;
      wake_cond_q <= next_wake_cond;
      periph_irq  <= next_irq_cond;
      wake_req    <= next_wake_cond;
      evt_status  <= next_evt_status;
      irq         <= |(next_evt_status & evt_mask);
    end
  end

endmodule

// [hdl/pif_defs.vh]
// Register map, field positions and reset values of the peripheral flag block
`ifndef PIF_DEFS_VH
`define PIF_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PIF_OFS_FLAGS_ONE   8'h00
`define PIF_OFS_FLAGS_TWO   8'h04
`define PIF_OFS_FLAGS_THREE 8'h08
`define PIF_OFS_EN_ONE      8'h0C
`define PIF_OFS_EN_TWO      8'h10
`define PIF_OFS_EN_THREE    8'h14
`define PIF_OFS_CORE_CTRL   8'h18
`define PIF_OFS_EVT_STATUS  8'h1C
`define PIF_OFS_EVT_MASK    8'h20

// ------------------------------------------------------------
// Flag positions, first register
// ------------------------------------------------------------
`define PIF_B1_TIMER1_GATE  7
`define PIF_B1_ADC_DONE     6
`define PIF_B1_UART_RX      5
`define PIF_B1_UART_TX      4
`define PIF_B1_SYNC_SERIAL  3
`define PIF_B1_CAPTURE1     2
`define PIF_B1_TIMER2_MATCH 1
`define PIF_B1_TIMER1_OVF   0

// ------------------------------------------------------------
// Flag positions, second and third register
// ------------------------------------------------------------
`define PIF_B2_OSC_FAIL     7
`define PIF_B2_COMPARATOR2  6
`define PIF_B2_COMPARATOR1  5
`define PIF_B2_EEPROM_DONE  4
`define PIF_B2_BUS_COLL     3
`define PIF_B2_CAPTURE2     0
`define PIF_B3_CAPTURE4     5
`define PIF_B3_CAPTURE3     4
`define PIF_B3_TIMER6_MATCH 3
`define PIF_B3_TIMER4_MATCH 1

// ------------------------------------------------------------
// Implemented and writable bit masks
// ------------------------------------------------------------
`define PIF_IMPL_ONE        8'hFF
`define PIF_WR_ONE          8'hCF
`define PIF_IMPL_TWO_SMALL  8'hB9
`define PIF_IMPL_TWO_LARGE  8'hF9
`define PIF_IMPL_THREE      8'h3A

// ------------------------------------------------------------
// Core control and event fields
// ------------------------------------------------------------
`define PIF_CC_GLOBAL_EN    7
`define PIF_CC_PERIPH_EN    6
`define PIF_CC_MASK         8'hC0
`define PIF_EVT_IRQ_RAISED  0
`define PIF_EVT_WAKE_RAISED 1
`define PIF_EVT_MASK        8'h03

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PIF_RST_FLAGS       8'h00
`define PIF_RST_ENABLES     8'h00
`define PIF_RST_CTRL        8'h00
`define PIF_RST_DATA        32'h0000_0000

`endif

// [bench/pif_flags_asserts.sv]
// Port-level concurrent checks for the peripheral flag block
`timescale 1ns/1ps
`include "pif_defs.vh"
// ----------------------------------------
// Checker
// ----------------------------------------
module pif_flags_asserts (
  // System
  input logic        clk_sys,
  input logic        rstn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Requests
  input logic        timer1_overflow_set,
  input logic        periph_irq,
  input logic        wake_req,
  input logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire rd = pready && !pwrite;
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait cycle");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > `PIF_OFS_EVT_MASK))
    else $error("pslverr wrong for address");
  a_err_data: assert property (pslverr |-> prdata == 32'h0) else $error("data on error");
  a_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  a_two_gaps: assert property (rd && paddr == `PIF_OFS_FLAGS_TWO |-> prdata[2:1] == 2'h0)
    else $error("gap bits of flags two set");
  a_three_gaps: assert property (rd && paddr == `PIF_OFS_FLAGS_THREE |->
    (prdata[7:0] & ~`PIF_IMPL_THREE) == 8'h0) else $error("gap bits of flags three set");
  a_pend_read: assert property (rd && paddr == `PIF_OFS_FLAGS_ONE &&
    $past(timer1_overflow_set, 2) && $past(timer1_overflow_set, 3) |-> prdata[0])
    else $error("held request not pending");
  a_wake_cover: assert property (periph_irq |-> wake_req) else $error("irq without wake");
  a_reset_quiet: assert property ($rose(rstn) |-> !irq && !wake_req && !periph_irq && !pready)
    else $error("outputs active after reset");
  c_unmapped: cover property (pslverr);
  c_irq: cover property ($rose(irq));
  c_periph: cover property ($rose(periph_irq));
endmodule

// [bench/pif_periph_model.sv]
// Behavioural peripherals raising set requests toward the flag block
`timescale 1ns/1ps
// ----------------------------------------
// Peripheral model
// ----------------------------------------
module pif_periph_model #(
  parameter int DLY = 2
) (
  // System
  input  logic        clk_sys,
  input  logic        rstn,
  // Bench commands
  input  logic [23:0] req,
  input  logic [23:0] hold,
  input  logic [1:0]  clr_req,
  // Toward the flag block
  output logic [23:0] set_o,
  output logic [1:0]  clr_o
);
  // Absent peripherals never raise anything
  localparam logic [23:0] PRESENT = 24'h3A_F9FF;
  logic [23:0] pipe [0:3];
  always @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) pipe[i] <= 24'h0;
      clr_o <= 2'h0;
    end else begin
      pipe[0] <= req;
      for (int i = 1; i < 4; i++) pipe[i] <= pipe[i-1];
      clr_o <= clr_req;
    end
  end
  // Late one-cycle pulses; hold models a condition that stays up
  assign set_o = (pipe[DLY-1] | hold) & PRESENT;
endmodule

// [bench/testbench.sv]
// Self-checking bench for the peripheral flag block
`timescale 1ns/1ps
`include "pif_defs.vh"
// ----------------------------------------
// Bench
// ----------------------------------------
module testbench;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [23:0] req = 24'h0;
  logic [23:0] hold = 24'h0;
  logic [1:0]  clr_req = 2'h0;
  logic [23:0] s;
  logic [1:0]  c;
  logic        periph_irq;
  logic        wake_req;
  logic        irq;
  logic [7:0]  exp_f [0:2];
  logic [31:0] rd;
  logic [31:0] prdata_s;
  logic [31:0] rd_s;
  logic        er;
  int          errors = 0;
  int          num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  pif_periph_model #(.DLY(2)) u_per (.clk_sys(clk_sys), .rstn(rstn), .req(req), .hold(hold),
    .clr_req(clr_req), .set_o(s), .clr_o(c));
  pif_flags #(.LARGE_VARIANT(1)) dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_gate_set(s[7]), .adc_done_set(s[6]), .uart_rx_set(s[5]), .uart_tx_set(s[4]),
    .sync_serial_set(s[3]), .capture1_set(s[2]), .timer2_match_set(s[1]), .timer1_overflow_set(s[0]),
    .uart_rx_clr(c[1]), .uart_tx_clr(c[0]), .osc_fail_set(s[15]), .comparator2_set(s[14]),
    .comparator1_set(s[13]), .eeprom_write_done_set(s[12]), .bus_collision_set(s[11]),
    .capture2_set(s[8]), .capture4_set(s[21]), .capture3_set(s[20]), .timer6_match_set(s[19]),
    .timer4_match_set(s[17]), .periph_irq(periph_irq), .wake_req(wake_req), .irq(irq));
  // Smaller variant on the same stimulus: comparator2 must stay absent
  pif_flags #(.LARGE_VARIANT(0)) dut_small (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_s), .pready(), .pslverr(),
    .timer1_gate_set(s[7]), .adc_done_set(s[6]), .uart_rx_set(s[5]), .uart_tx_set(s[4]),
    .sync_serial_set(s[3]), .capture1_set(s[2]), .timer2_match_set(s[1]), .timer1_overflow_set(s[0]),
    .uart_rx_clr(c[1]), .uart_tx_clr(c[0]), .osc_fail_set(s[15]), .comparator2_set(s[14]),
    .comparator1_set(s[13]), .eeprom_write_done_set(s[12]), .bus_collision_set(s[11]),
    .capture2_set(s[8]), .capture4_set(s[21]), .capture3_set(s[20]), .timer6_match_set(s[19]),
    .timer4_match_set(s[17]), .periph_irq(), .wake_req(), .irq());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait on pready; read data and error taken at that edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rd_s = prdata_s;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      end_of_test;
    end
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input logic [23:0] r, input logic [1:0] cr);
    @(posedge clk_sys);
    req <= r;
    clr_req <= cr;
    @(posedge clk_sys);
    req <= 24'h0;
    clr_req <= 2'h0;
    settle;
  endtask
  // Software-writable bits of each flag register
  function automatic logic [7:0] wmask(input int k);
    return k == 0 ? `PIF_WR_ONE : (k == 1 ? `PIF_IMPL_TWO_LARGE : `PIF_IMPL_THREE);
  endfunction
  initial begin
    logic [23:0] ev;
    logic [31:0] d;
    logic [1:0]  cr;
    int          k;
    void'($urandom(32'hece1));
    // Second pass resets with flags set
    for (int p = 0; p < 2; p++) begin
      rstn <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      for (k = 0; k < 3; k++) exp_f[k] = 8'h0;
      for (int a = 0; a <= 36; a += 4) begin
        apb(1'b0, 8'(a), 32'h0);
        chk(rd, 32'h0);
        chk(rd_s, 32'h0);
        chk(er, a == 36);
      end
      repeat (25) begin
        ev = 24'($urandom);
        pulse(ev, 2'h0);
        for (k = 0; k < 3; k++) exp_f[k] |= ev[8*k +: 8] & (k == 0 ? 8'hFF : wmask(k));
        k = $urandom_range(2);
        d = $urandom;
        apb(1'b1, 8'(4 * k), d);
        exp_f[k] = (exp_f[k] & ~wmask(k)) | (d[7:0] & wmask(k));
        cr = 2'($urandom);
        pulse(24'h0, cr);
        exp_f[0] &= ~{2'h0, cr, 4'h0};
        for (k = 0; k < 3; k++) begin
          apb(1'b0, 8'(4 * k), 32'h0);
          chk(rd, {24'h0, exp_f[k]});
          chk(rd_s, {24'h0, exp_f[k] & (k == 1 ? `PIF_IMPL_TWO_SMALL : 8'hFF)});
        end
      end
    end
    @(posedge clk_sys);
    hold <= 24'h1;
    settle;
    apb(1'b1, `PIF_OFS_FLAGS_ONE, 32'h0);
    apb(1'b0, `PIF_OFS_FLAGS_ONE, 32'h0);
    chk(rd[0], 1'b1);
    @(posedge clk_sys);
    hold <= 24'h0;
    apb(1'b1, `PIF_OFS_FLAGS_ONE, 32'h0);
    apb(1'b0, `PIF_OFS_FLAGS_ONE, 32'h0);
    chk(rd, {24'h0, exp_f[0] & 8'h30});
    // Flag is clear before its enable goes on
    apb(1'b1, `PIF_OFS_EN_ONE, 32'h1);
    pulse(24'h1, 2'h0);
    chk(wake_req, 1'b1);
    chk(periph_irq, 1'b0);
    apb(1'b1, `PIF_OFS_CORE_CTRL, 32'h40);
    settle;
    chk(periph_irq, 1'b1);
    apb(1'b0, `PIF_OFS_EVT_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 1'b0);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, k[0] ? `PIF_OFS_EVT_STATUS : `PIF_OFS_EVT_MASK, 32'(k / 2 + 1));
      settle;
      chk(irq, !k[0]);
      if (k == 2) begin
        apb(1'b1, `PIF_OFS_FLAGS_ONE, 32'h0);
        settle;
        chk({wake_req, periph_irq, irq}, 3'b001);
      end
    end
    end_of_test;
  end
endmodule
bind pif_flags pif_flags_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer1_overflow_set(timer1_overflow_set), .periph_irq(periph_irq), .wake_req(wake_req), .irq(irq));
